/* File: verilog/soi_serial_opcode_interface.sv */
// Serial opcode interface: SPI mode 1 slave that decodes control, memory, config and result opcodes.
`timescale 1ns/1ns
module soi_serial_opcode_interface (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     interfaceSelectPin,
   input  wire logic                     spiClock,
   input  wire logic                     slaveSelectLowN,
   input  wire logic                     spiDataIn,
   output logic                          generalPortOneOut,
   output logic                          generalPortOneOe,
   output soi_pkg::soi_pulse_type        cmdPulse,
   output soi_pkg::soi_mem_req_type      memReq,
   input  wire logic [7:0]               memRdData,
   output logic [5:0]                    resultIndex,
   output logic                          resultRead,
   input  wire logic [47:0]              resultData,
   input  wire logic [4:0]               cfgReadIndex,
   output logic [23:0]                   cfgReadData
);
   import soi_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic            sclkPrev;
      logic [5:0]      bitCount;
      logic [31:0]     rxShift;
      logic [47:0]     txShift;
      logic            loadPending;
      logic            loadFromMemory;
      soi_cmd_type     kind;
      logic            sdo;
      logic            sdoOe;
      soi_pulse_type   pulse;
      soi_mem_req_type mem;
      logic [5:0]      resultIndex;
      logic            resultRead;
      soi_cfg_wr_type  cfgWr;
      logic            cfgClear;
      logic            tempSoftware;
   } soi_state_type;

   soi_state_type s_q;
   soi_state_type s_d;

   logic        linkActive;
   logic        fallEdge;
   logic        riseEdge;
   logic [31:0] rxNext;
   logic [5:0]  countNext;

   // ==========================================================
   // Edge detection on the host clock
   // The host clock is taken as synchronous to clk, so edges come from
   // the previous sample alone; it must stay well below clk/2.
   assign fallEdge   = s_q.sclkPrev & ~spiClock;
   assign riseEdge   = ~s_q.sclkPrev & spiClock;
   assign linkActive = ~interfaceSelectPin & ~slaveSelectLowN;
   assign rxNext     = {s_q.rxShift[30:0], spiDataIn};
   assign countNext  = s_q.bitCount + 6'h01;

   // ==========================================================
   // Next-state logic
   always_comb begin
      s_d = s_q;
      s_d.sclkPrev     = spiClock;
      s_d.pulse        = '0;
      s_d.mem.write    = 1'b0;
      s_d.mem.read     = 1'b0;
      s_d.resultRead   = 1'b0;
      s_d.cfgWr.write  = 1'b0;
      s_d.cfgClear     = 1'b0;

      if (!linkActive) begin
         // Dropping select throws away whatever was half received.
         s_d.bitCount    = 6'h00;
         s_d.kind        = CMD_NONE;
         s_d.loadPending = 1'b0;
         s_d.sdo         = 1'b0;
         s_d.sdoOe       = 1'b0;
      end else begin
         s_d.sdoOe = 1'b1;

         // ------------------------------------------------------
         // Receive: sample on the falling edge
         if (fallEdge && (s_q.kind != CMD_DONE) && (s_q.kind != CMD_READOUT)) begin
            s_d.rxShift  = rxNext;
            s_d.bitCount = countNext;
            case (s_q.kind)
               CMD_NONE: begin
                  if (countNext == BITS_OPCODE) begin
                     s_d.kind = CMD_DONE;
                     if (rxNext[7:0] == OP_POWER_UP_RESET) begin
                        s_d.pulse.powerUpReset = 1'b1;
                        s_d.cfgClear           = 1'b1;
                        s_d.tempSoftware       = 1'b1;
                     end else if (rxNext[7:0] == OP_PARTIAL_RESET) begin
                        s_d.pulse.partialReset = 1'b1;
                     end else if (rxNext[7:0] == OP_CAP_START) begin
                        s_d.pulse.capStart = 1'b1;
                     end else if (rxNext[7:0] == OP_OTP_END) begin
                        s_d.pulse.otpWriteEnd = 1'b1;
                     end else if (rxNext[7:0] == OP_TEMP_START) begin
                        s_d.pulse.tempStart = s_q.tempSoftware;
                     end else if (rxNext[7:4] == CODE_SRAM_WRITE) begin
                        s_d.kind = CMD_SRAM_WR;
                     end else if (rxNext[7:4] == CODE_SRAM_READ) begin
                        s_d.kind = CMD_SRAM_RD;
                     end else if (rxNext[7:5] == CODE_OTP_WRITE) begin
                        s_d.kind = CMD_OTP_WR;
                     end else if (rxNext[7:5] == CODE_OTP_READ) begin
                        s_d.kind = CMD_OTP_RD;
                     end else if (rxNext[7:6] == CODE_CFG_WRITE) begin
                        s_d.kind = CMD_CFG_WR;
                     end else if (rxNext[7:6] == CODE_RES_READ) begin
                        // Result address is complete after the first byte.
                        s_d.kind           = CMD_READOUT;
                        s_d.resultIndex    = rxNext[5:0];
                        s_d.resultRead     = 1'b1;
                        s_d.loadPending    = 1'b1;
                        s_d.loadFromMemory = 1'b0;
                     end
                  end
               end
               CMD_SRAM_RD, CMD_OTP_RD: begin
                  if (countNext == BITS_MEMADDR) begin
                     s_d.kind           = CMD_READOUT;
                     s_d.mem.read       = 1'b1;
                     s_d.mem.otp        = (s_q.kind == CMD_OTP_RD);
                     // SRAM ignores address bit 12, which holds a code bit.
                     s_d.mem.addr       = (s_q.kind == CMD_OTP_RD) ?
                                          rxNext[12:0] : {1'b0, rxNext[11:0]};
                     s_d.loadPending    = 1'b1;
                     s_d.loadFromMemory = 1'b1;
                  end
               end
               CMD_SRAM_WR, CMD_OTP_WR: begin
                  if (countNext == BITS_MEMCMD) begin
                     s_d.kind       = CMD_DONE;
                     s_d.mem.write  = 1'b1;
                     s_d.mem.otp    = (s_q.kind == CMD_OTP_WR);
                     s_d.mem.addr   = (s_q.kind == CMD_OTP_WR) ?
                                      rxNext[20:8] : {1'b0, rxNext[19:8]};
                     s_d.mem.wrData = rxNext[7:0];
                  end
               end
               CMD_CFG_WR: begin
                  if (countNext == BITS_CFGCMD) begin
                     s_d.kind = CMD_DONE;
                     // Indices past the last cell are dropped, not wrapped.
                     if (rxNext[29:24] <= CFG_LAST_INDEX) begin
                        s_d.cfgWr.write = 1'b1;
                        s_d.cfgWr.index = rxNext[28:24];
                        s_d.cfgWr.data  = rxNext[23:0];
                        if (rxNext[28:24] == REG_MEAS_TRIGGER_CYCLE) begin
                           s_d.tempSoftware =
                              (rxNext[TEMP_TRIG_LSB +: 2] == TEMP_TRIG_SOFTWARE);
                        end
                     end
                  end
               end
               default: begin
                  s_d.kind = CMD_DONE;
               end
            endcase
         end

         // ------------------------------------------------------
         // Transmit: change the data line on the rising edge
         if (riseEdge) begin
            if (s_q.loadPending) begin
               // Memory byte sits in the top of the word; the rest shifts as zero.
               if (s_q.loadFromMemory) begin
                  s_d.txShift = {memRdData[6:0], 41'h0};
                  s_d.sdo     = memRdData[7];
               end else begin
                  s_d.txShift = {resultData[46:0], 1'b0};
                  s_d.sdo     = resultData[47];
               end
               s_d.loadPending = 1'b0;
            end else if (s_q.kind == CMD_READOUT) begin
               s_d.sdo     = s_q.txShift[47];
               s_d.txShift = {s_q.txShift[46:0], 1'b0};
            end else begin
               s_d.sdo = 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q.sclkPrev       <= 1'b0;
         s_q.bitCount       <= 6'h00;
         s_q.rxShift        <= 32'h00000000;
         s_q.txShift        <= 48'h000000000000;
         s_q.loadPending    <= 1'b0;
         s_q.loadFromMemory <= 1'b0;
         s_q.kind           <= CMD_NONE;
         s_q.sdo            <= 1'b0;
         s_q.sdoOe          <= 1'b0;
         s_q.pulse          <= '0;
         s_q.mem            <= '0;
         s_q.resultIndex    <= 6'h00;
         s_q.resultRead     <= 1'b0;
         s_q.cfgWr          <= '0;
         s_q.cfgClear       <= 1'b0;
         s_q.tempSoftware   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Configuration store
   // The store has no path back to the serial link, only to the hardware it steers.
   soi_config_cells u_cells (
      .clk     (clk),
      .rst_n   (rst_n),
      .clear   (s_q.cfgClear),
      .cfgWr   (s_q.cfgWr),
      .rdIndex (cfgReadIndex),
      .rdData  (cfgReadData)
   );

   // ==========================================================
   // Outputs
   assign generalPortOneOut = s_q.sdo;
   assign generalPortOneOe  = s_q.sdoOe;
   assign cmdPulse          = s_q.pulse;
   assign memReq            = s_q.mem;
   assign resultIndex       = s_q.resultIndex;
   assign resultRead        = s_q.resultRead;

endmodule

/* File: verilog/soi_pkg.sv */
// Shared constants and types for the serial opcode interface.
package soi_pkg;

   // ==========================================================
   // Single-byte opcodes
   localparam logic [7:0] OP_POWER_UP_RESET = 8'h88;
   localparam logic [7:0] OP_PARTIAL_RESET  = 8'h8a;
   localparam logic [7:0] OP_CAP_START      = 8'h8c;
   localparam logic [7:0] OP_OTP_END        = 8'h84;
   localparam logic [7:0] OP_TEMP_START     = 8'h8e;

   // ==========================================================
   // Command codes in the top bits of the first byte
   localparam logic [3:0] CODE_SRAM_WRITE = 4'h9;
   localparam logic [3:0] CODE_SRAM_READ  = 4'h1;
   localparam logic [2:0] CODE_OTP_WRITE  = 3'h5;
   localparam logic [2:0] CODE_OTP_READ   = 3'h1;
   localparam logic [1:0] CODE_CFG_WRITE  = 2'h3;
   localparam logic [1:0] CODE_RES_READ   = 2'h1;

   // ==========================================================
   // Frame lengths in bits
   localparam logic [5:0] BITS_OPCODE  = 6'h08;
   localparam logic [5:0] BITS_MEMADDR = 6'h10;
   localparam logic [5:0] BITS_MEMCMD  = 6'h18;
   localparam logic [5:0] BITS_CFGCMD  = 6'h20;

   // ==========================================================
   // Cell map
   localparam int unsigned CFG_CELL_COUNT = 21;
   localparam logic [5:0]  CFG_LAST_INDEX = 6'h14;
   localparam logic [5:0]  RES_LAST_INDEX = 6'h0e;
   localparam logic [23:0] CFG_RESET_VALUE = 24'h000000;

   localparam logic [4:0] REG_OTP_SETTINGS        = 5'h00;
   localparam logic [4:0] REG_FIXED_DEFAULT_A     = 5'h01;
   localparam logic [4:0] REG_CAP_PORT_SCHEME     = 5'h02;
   localparam logic [4:0] REG_CAP_TIMING_AVERAGE  = 5'h03;
   localparam logic [4:0] REG_MEAS_TRIGGER_CYCLE  = 5'h04;
   localparam logic [4:0] REG_TEMP_AVERAGE_PREDIV = 5'h05;
   localparam logic [4:0] REG_TEMP_FAKE_SELECT    = 5'h06;
   localparam logic [4:0] REG_FIXED_DEFAULT_B     = 5'h07;
   localparam logic [4:0] REG_PROCESSOR_CONFIG    = 5'h08;
   localparam logic [4:0] REG_PORT_PULSE_CONFIG   = 5'h09;
   localparam logic [4:0] REG_REGULATOR_CONTROL   = 5'h0a;

   // Temperature trigger select field inside the trigger cell.
   localparam int unsigned TEMP_TRIG_LSB      = 0;
   localparam logic [1:0]  TEMP_TRIG_SOFTWARE = 2'h0;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      CMD_NONE      = 3'b000,
      CMD_SRAM_WR   = 3'b001,
      CMD_SRAM_RD   = 3'b010,
      CMD_OTP_WR    = 3'b011,
      CMD_OTP_RD    = 3'b100,
      CMD_CFG_WR    = 3'b101,
      CMD_READOUT   = 3'b110,
      CMD_DONE      = 3'b111
   } soi_cmd_type;

   typedef struct packed {
      logic powerUpReset;
      logic partialReset;
      logic capStart;
      logic otpWriteEnd;
      logic tempStart;
   } soi_pulse_type;

   typedef struct packed {
      logic        write;
      logic        read;
      logic        otp;
      logic [12:0] addr;
      logic [7:0]  wrData;
   } soi_mem_req_type;

   typedef struct packed {
      logic        write;
      logic [4:0]  index;
      logic [23:0] data;
   } soi_cfg_wr_type;

endpackage

/* File: verilog/soi_config_cells.sv */
// Write-only configuration and parameter cell store with one registered read port.
`timescale 1ns/1ns
module soi_config_cells (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    clear,
   input  wire soi_pkg::soi_cfg_wr_type cfgWr,
   input  wire logic [4:0]              rdIndex,
   output logic [23:0]                  rdData
);
   import soi_pkg::*;

   typedef struct packed {
      logic [CFG_CELL_COUNT-1:0][23:0] cells;
      logic [23:0]                     rdData;
   } soi_cells_state_type;

   soi_cells_state_type s_q;
   soi_cells_state_type s_d;

   always_comb begin
      s_d = s_q;
      if (clear) begin
         for (int i = 0; i < CFG_CELL_COUNT; i++) begin
            s_d.cells[i] = CFG_RESET_VALUE;
         end
      end else if (cfgWr.write && (cfgWr.index <= CFG_LAST_INDEX[4:0])) begin
         s_d.cells[cfgWr.index] = cfgWr.data;
      end
      // Out-of-range indices read as zero rather than aliasing a cell.
      if (rdIndex <= CFG_LAST_INDEX[4:0]) begin
         s_d.rdData = s_q.cells[rdIndex];
      end else begin
         s_d.rdData = 24'h000000;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < CFG_CELL_COUNT; i++) begin
            s_q.cells[i] <= CFG_RESET_VALUE;
         end
         s_q.rdData <= 24'h000000;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdData = s_q.rdData;

endmodule

/* File: test/soi_spi_host_model.sv */
// Host model that drives the serial link in mode 1, one command per select-low period.
`timescale 1ns/1ns
module soi_spi_host_model #(
   parameter int HALF = 6
) (
   input  wire logic clk,
   output logic      spiClock,
   output logic      slaveSelectLowN,
   output logic      spiDataIn,
   input  wire logic generalPortOneOut,
   input  wire logic generalPortOneOe
);
   initial begin
      spiClock        = 1'b0;
      slaveSelectLowN = 1'b1;
      spiDataIn       = 1'b0;
   end

   // ==========================================================
   // Frame transfer
   // Shifts nbits of tx MSB first; a frame is cut short after abortAt bits.
   task automatic xfer(input logic [63:0] tx, input int nbits, input int abortAt,
                       output logic [63:0] rx);
      rx = '0;
      slaveSelectLowN = 1'b0;
      repeat (HALF) @(negedge clk);
      for (int i = nbits - 1; i >= 0; i--) begin
         if (nbits - 1 - i == abortAt)
            break;
         spiClock  = 1'b1;
         spiDataIn = tx[i];
         repeat (HALF) @(negedge clk);
         // An undriven data line reads as the inverse, so a released output cannot pass.
         rx       = {rx[62:0], generalPortOneOe ? generalPortOneOut : ~generalPortOneOut};
         spiClock = 1'b0;
         repeat (HALF) @(negedge clk);
      end
      slaveSelectLowN = 1'b1;
      // A released data line must not keep looking valid.
      spiDataIn = ~spiDataIn;
      repeat (2 * HALF) @(negedge clk);
   endtask
endmodule

/* File: test/soi_serial_opcode_interface_sva.sv */
// Concurrent assertions on the serial opcode interface ports.
`timescale 1ns/1ns
module soi_serial_opcode_interface_sva (
   input wire logic                     clk,
   input wire logic                     rst_n,
   input wire logic                     interfaceSelectPin,
   input wire logic                     spiClock,
   input wire logic                     slaveSelectLowN,
   input wire logic                     generalPortOneOut,
   input wire logic                     generalPortOneOe,
   input wire soi_pkg::soi_pulse_type   cmdPulse,
   input wire soi_pkg::soi_mem_req_type memReq,
   input wire logic [5:0]               resultIndex,
   input wire logic                     resultRead,
   input wire logic [4:0]               cfgReadIndex,
   input wire logic [23:0]              cfgReadData
);
   import soi_pkg::*;

   // ==========================================================
   // Link sequences
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence selHeld;
      (!slaveSelectLowN && !interfaceSelectPin) [*2];
   endsequence

   // The bit was taken on the previous edge, so answers trail the fall by one clock.
   sequence fallTaken;
      $past(spiClock, 2) && !$past(spiClock);
   endsequence

   sequence riseSeen;
      $past(spiClock) && !$past(spiClock, 2);
   endsequence

   // ==========================================================
   // Assertions
   a_pulse_onehot: assert property ($onehot0(cmdPulse))
      else $error("more than one command pulse");
   a_pulse_timing: assert property (|cmdPulse |-> fallTaken ##0 !$past(slaveSelectLowN))
      else $error("command pulse not after a framed fall");
   a_pulse_single: assert property (|cmdPulse |=> cmdPulse == '0)
      else $error("command pulse longer than one cycle");
   a_mem_timing: assert property ((memReq.write || memReq.read) |->
      fallTaken ##1 (!memReq.write && !memReq.read))
      else $error("memory request timing wrong");
   a_mem_hold: assert property (!memReq.write && !memReq.read |->
      $stable(memReq.addr) && $stable(memReq.otp))
      else $error("memory request fields moved");
   a_result_timing: assert property (resultRead |-> fallTaken ##1 !resultRead)
      else $error("result read pulse timing wrong");
   a_result_hold: assert property (!resultRead |-> $stable(resultIndex))
      else $error("result index moved");
   a_cfg_unmapped: assert property (cfgReadIndex > 5'h14 |=> cfgReadData == 24'h000000)
      else $error("unmapped cell read not zero");
   a_oe_release: assert property (slaveSelectLowN || interfaceSelectPin |=>
      !generalPortOneOe)
      else $error("data out driven while deselected");
   a_oe_drive: assert property (selHeld |-> generalPortOneOe)
      else $error("data out not driven while selected");
   a_out_on_rise: assert property ($changed(generalPortOneOut) && generalPortOneOe &&
      $past(generalPortOneOe) |-> riseSeen)
      else $error("data out changed off a rising clock");
endmodule

bind soi_serial_opcode_interface soi_serial_opcode_interface_sva u_sva (
   .clk(clk), .rst_n(rst_n), .interfaceSelectPin(interfaceSelectPin),
   .spiClock(spiClock), .slaveSelectLowN(slaveSelectLowN),
   .generalPortOneOut(generalPortOneOut), .generalPortOneOe(generalPortOneOe),
   .cmdPulse(cmdPulse), .memReq(memReq), .resultIndex(resultIndex),
   .resultRead(resultRead), .cfgReadIndex(cfgReadIndex), .cfgReadData(cfgReadData)
);

/* File: test/soi_serial_opcode_interface_tb.sv */
// Self-checking bench for the serial opcode interface.
`timescale 1ns/1ns
module soi_serial_opcode_interface_tb;
   import soi_pkg::*;

   logic            clk, rst_n, interfaceSelectPin, resultRead, readSeen;
   logic            spiClock, slaveSelectLowN, spiDataIn, generalPortOneOut, generalPortOneOe;
   soi_pulse_type   cmdPulse;
   soi_mem_req_type memReq, lastReq;
   logic [7:0]      memRdData;
   logic [5:0]      resultIndex;
   logic [47:0]     resultData;
   logic [4:0]      cfgReadIndex, seen;
   logic [23:0]     cfgReadData;
   logic [63:0]     rx;
   int              bad_count, samples_checked, cycles;
   logic [7:0]      opc [6] = '{OP_POWER_UP_RESET, OP_PARTIAL_RESET, OP_CAP_START,
                                OP_OTP_END, OP_TEMP_START, 8'h80};
   logic [23:0]     memTx [4] = '{24'h9047ff, 24'hbabc5a, 24'h18c300, 24'h2f0f00};
   logic [15:0]     memExp [4] = '{16'h8047, 16'hbabc, 16'h48c3, 16'h6f0f};

   soi_serial_opcode_interface dut (
      .clk(clk), .rst_n(rst_n), .interfaceSelectPin(interfaceSelectPin),
      .spiClock(spiClock), .slaveSelectLowN(slaveSelectLowN), .spiDataIn(spiDataIn),
      .generalPortOneOut(generalPortOneOut), .generalPortOneOe(generalPortOneOe),
      .cmdPulse(cmdPulse), .memReq(memReq), .memRdData(memRdData),
      .resultIndex(resultIndex), .resultRead(resultRead), .resultData(resultData),
      .cfgReadIndex(cfgReadIndex), .cfgReadData(cfgReadData)
   );

   soi_spi_host_model host (
      .clk(clk), .spiClock(spiClock), .slaveSelectLowN(slaveSelectLowN),
      .spiDataIn(spiDataIn), .generalPortOneOut(generalPortOneOut),
      .generalPortOneOe(generalPortOneOe)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ==========================================================
   // Monitors and helpers
   always @(posedge clk) begin
      cycles <= cycles + 1;
      seen     <= seen | cmdPulse;
      readSeen <= readSeen | resultRead;
      if (memReq.write || memReq.read)
         lastReq <= memReq;
      if (cycles == 20000) begin
         bad_count++;
         results();
      end
   end

   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic send(input logic [63:0] tx, input int n);
      seen     = '0;
      readSeen = 1'b0;
      lastReq  = '0;
      host.xfer(tx, n, -1, rx);
   endtask

   task automatic results();
      if (bad_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   initial begin
      rst_n              = 1'b0;
      interfaceSelectPin = 1'b0;
      memRdData          = 8'ha5;
      resultData         = 48'h1234569abcde;
      cfgReadIndex       = 5'h04;
      bad_count          = 0;
      samples_checked    = 0;
      cycles             = 0;
      seen               = '0;
      readSeen           = 1'b0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      for (int i = 0; i < 6; i++) begin
         send({56'h0, opc[i]}, 8);
         check(seen, 64'h10 >> i, "single-byte pulse");
      end
      send(64'hc4000001, 32);
      check(cfgReadData, 24'h000001, "cell 4 stored");
      send(64'h8e, 8);
      check(seen, 5'h00, "temperature blocked");
      send(64'h8a, 8);
      check(cfgReadData, 24'h000001, "cell kept");
      cfgReadIndex = 5'h14;
      send(64'hd4abcdef, 32);
      check(cfgReadData, 24'habcdef, "last cell");
      cfgReadIndex = 5'h15;
      send(64'hd5777777, 32);
      check(cfgReadData, 24'h000000, "no cell 21");
      cfgReadIndex = 5'h04;
      send(64'h88, 8);
      check(cfgReadData, 24'h000000, "cells cleared");
      send(64'h8e, 8);
      check(seen, 5'h01, "temperature enabled again");
      for (int i = 0; i < 4; i++) begin
         send({40'h0, memTx[i]}, 24);
         check(lastReq[23:8], memExp[i], "memory request");
         check(readSeen, 1'b0, "no result strobe");
         if (i < 2)
            check(lastReq.wrData, memTx[i][7:0], "write byte");
         else
            check(rx[7:0], 8'ha5, "read byte");
      end
      send(64'h004e000000000000, 56);
      check(rx[47:0], 48'h1234569abcde, "wide result");
      check(resultIndex, 6'h0e, "result index");
      check(readSeen, 1'b1, "result strobe");
      send(64'h43000000, 32);
      check(rx[23:0], 24'h123456, "narrow result");
      seen = '0;
      host.xfer(64'h8c, 8, 4, rx);
      check(seen, 5'h00, "aborted frame");
      send(64'h8c, 8);
      check(seen, 5'h04, "frame after abort");
      interfaceSelectPin = 1'b1;
      send(64'h8c, 8);
      check(seen, 5'h00, "link deselected");
      check(generalPortOneOe, 1'b0, "data out released");
      results();
   end
endmodule
